// ===== design/udr_pkg.sv
// Purpose: Constants and carriers for the default descriptor store
// Assumes: One clock, synchronous active-high reset
// Notes: Serves the default configuration descriptor set, bytes in stored order
// Overview of operation
// - Configuration byte 8 is 32H: 100 mA bus power.
// - Total length counts every following interface and endpoint descriptor.
// - Configuration reports exactly one interface at byte 4.
// - Interface descriptors: 9 bytes, type 04H, number 0, class bytes FFH.
// - Alternate setting 0 reports zero endpoints.
// - Alternate setting 1: value 01H, 0DH endpoints following directly.
// - Interface string index byte is always 00H.
// - Endpoint descriptors: 7 bytes, type 05H, bit 7 set for IN.
// - Interrupt IN 1: address 81H, attribute 03H, 16 bytes, interval 0AH.
// - Six bulk endpoints 2,4,6 both ways: 02H, 40H size, interval 00H.
// - Bulk endpoints use even numbers to allow later pairing.
// - Six iso endpoints 8,9,10 both ways: 01H, size 10H, interval 01H.
// - Alternate setting 2: value 02H, thirteen endpoints, else as setting 1.
// - Setting 2 differs only in its value and in interrupt and endpoint 8 packet sizes.
// - Setting 2 interrupt IN 1 packet size is 64 bytes.
// - Setting 2 iso endpoint 8 IN and OUT packet size is 256 bytes.
// - Serve only while firmware takeover flag is zero.
package udr_pkg;
	localparam logic [7:0] DESC_TYPE_CONFIG = 8'h02;
	localparam logic [7:0] DESC_TYPE_IFACE = 8'h04;
	localparam logic [7:0] DESC_TYPE_EP = 8'h05;
	localparam logic [7:0] CFG_LEN = 8'h09;
	localparam logic [7:0] IFACE_LEN = 8'h09;
	localparam logic [7:0] EP_LEN = 8'h07;
	localparam logic [7:0] CFG_NUM_IFACES = 8'h01;
	localparam logic [7:0] CFG_VALUE = 8'h01;
	localparam logic [7:0] CFG_STRING = 8'h00;
	localparam logic [7:0] CFG_ATTR = 8'h80;
	localparam logic [7:0] CFG_MAX_POWER = 8'h32;
	localparam logic [7:0] IFACE_NUMBER = 8'h00;
	localparam logic [7:0] ALT0_VALUE = 8'h00;
	localparam logic [7:0] ALT1_VALUE = 8'h01;
	localparam logic [7:0] ALT2_VALUE = 8'h02;
	localparam logic [7:0] VENDOR_SPECIFIC = 8'hFF;
	localparam logic [7:0] IFACE_STRING = 8'h00;
	localparam logic [7:0] ALT0_EPS = 8'h00;
	localparam logic [7:0] ALTN_EPS = 8'h0D;
	localparam logic [7:0] ATTR_ISO = 8'h01;
	localparam logic [7:0] ATTR_BULK = 8'h02;
	localparam logic [7:0] ATTR_INT = 8'h03;
	localparam logic [7:0] INT_INTERVAL = 8'h0A;
	localparam logic [7:0] BULK_INTERVAL = 8'h00;
	localparam logic [7:0] ISO_INTERVAL = 8'h01;
	localparam logic [15:0] INT_MPS_ALT1 = 16'h0010;
	localparam logic [15:0] INT_MPS_ALT2 = 16'h0040;
	localparam logic [15:0] BULK_MPS = 16'h0040;
	localparam logic [15:0] ISO_MPS_LOW = 16'h0010;
	localparam logic [15:0] ISO8_MPS_ALT2 = 16'h0100;
	// Layout of the stored sequence
	localparam int NUM_EPS = 13;
	localparam logic [7:0] ALT0_BASE = 8'h09;
	localparam logic [7:0] ALT1_BASE = 8'h12;
	localparam logic [7:0] ALT2_BASE = 8'h76;
	localparam logic [7:0] ALT_EPS_OFS = 8'h09;
	localparam logic [15:0] TOTAL_LEN = 16'h00DA;
	// Endpoint slots: 0 interrupt, 1..6 bulk, 7..12 iso
	localparam logic [3:0] EP_FIRST_BULK = 4'h1;
	localparam logic [3:0] EP_FIRST_ISO = 4'h7;
	localparam logic [3:0] EP_ISO8_IN = 4'h7;
	localparam logic [3:0] EP_ISO8_OUT = 4'h8;
	localparam logic [7:0] EP_ADDR [NUM_EPS] = '{8'h81, 8'h82, 8'h02, 8'h84, 8'h04, 8'h86,
		8'h06, 8'h88, 8'h08, 8'h89, 8'h09, 8'h8A, 8'h0A};

	typedef enum logic [1:0]
	{
		UDR_IDLE = 2'b00,
		UDR_SERVE = 2'b01
	} udr_state_e;

	typedef struct packed
	{
		logic valid;
		logic [15:0] length;
	} udr_req_s;

	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
		logic last;
	} udr_byte_s;

	typedef struct packed
	{
		udr_state_e state;
		logic [7:0] index;
		logic [15:0] remain;
		udr_byte_s out;
		logic busy;
		logic done;
		logic refused;
	} udr_top_s;
endpackage : udr_pkg

// ===== design/udr_rom.sv
// Purpose: Byte lookup for the default configuration descriptor set
// Assumes: Index below the total length
// Notes: Purely combinational
`timescale 1ns/1ns
module udr_rom
	import udr_pkg::*;
(
	input wire logic [7:0] index,
	output logic [7:0] data
);
	logic [7:0] rel;
	logic [7:0] eprel;
	logic [3:0] slot;
	logic [2:0] pos;
	logic alt2;
	logic [15:0] mps;
	logic [7:0] ep_attr;
	logic [7:0] ep_ival;
	logic [7:0] ep_addr_tab [NUM_EPS];

	// Per-slot address lookup
	genvar g;
	generate
		for (g = 0; g < NUM_EPS; g++)
		begin : g_ep
			assign ep_addr_tab[g] = EP_ADDR[g];
		end
	endgenerate

	always_comb
	begin
		alt2 = (index >= ALT2_BASE);
		rel = alt2 ? 8'(index - ALT2_BASE) : 8'(index - ALT1_BASE);
		eprel = 8'(rel - ALT_EPS_OFS);
		slot = 4'(eprel / 8'(EP_LEN));
		pos = 3'(eprel % 8'(EP_LEN));
		mps = INT_MPS_ALT1;
		ep_attr = ATTR_INT;
		ep_ival = INT_INTERVAL;
		if (slot >= EP_FIRST_BULK && slot < EP_FIRST_ISO)
		begin
			mps = BULK_MPS;
			ep_attr = ATTR_BULK;
			ep_ival = BULK_INTERVAL;
		end
		else if (slot >= EP_FIRST_ISO)
		begin
			mps = ISO_MPS_LOW;
			ep_attr = ATTR_ISO;
			ep_ival = ISO_INTERVAL;
		end
		if (alt2)
		begin
			if (slot == 4'h0)
				mps = INT_MPS_ALT2;
			else if (slot == EP_ISO8_IN || slot == EP_ISO8_OUT)
				mps = ISO8_MPS_ALT2;
		end
		data = 8'h00;
		if (index < ALT0_BASE)
		begin
			case (index[3:0])
				4'h0: data = CFG_LEN;
				4'h1: data = DESC_TYPE_CONFIG;
				4'h2: data = TOTAL_LEN[7:0];
				4'h3: data = TOTAL_LEN[15:8];
				4'h4: data = CFG_NUM_IFACES;
				4'h5: data = CFG_VALUE;
				4'h6: data = CFG_STRING;
				4'h7: data = CFG_ATTR;
				4'h8: data = CFG_MAX_POWER;
				default: data = 8'h00;
			endcase
		end
		else if (index < ALT1_BASE || rel < ALT_EPS_OFS)
		begin
			if (index < ALT1_BASE)
				rel = 8'(index - ALT0_BASE);
			case (rel[3:0])
				4'h0: data = IFACE_LEN;
				4'h1: data = DESC_TYPE_IFACE;
				4'h2: data = IFACE_NUMBER;
				4'h3: data = (index < ALT1_BASE) ? ALT0_VALUE : (alt2 ? ALT2_VALUE : ALT1_VALUE);
				4'h4: data = (index < ALT1_BASE) ? ALT0_EPS : ALTN_EPS;
				4'h5: data = VENDOR_SPECIFIC;
				4'h6: data = VENDOR_SPECIFIC;
				4'h7: data = VENDOR_SPECIFIC;
				4'h8: data = IFACE_STRING;
				default: data = 8'h00;
			endcase
		end
		else if (slot < 4'(NUM_EPS))
		begin
			case (pos)
				3'h0: data = EP_LEN;
				3'h1: data = DESC_TYPE_EP;
				3'h2: data = ep_addr_tab[slot];
				3'h3: data = ep_attr;
				3'h4: data = mps[7:0];
				3'h5: data = mps[15:8];
				3'h6: data = ep_ival;
				default: data = 8'h00;
			endcase
		end
	end
endmodule : udr_rom

// ===== design/udr_top.sv
// Purpose: Serve the default configuration descriptor set as a byte stream
// Assumes: Request, ready and takeover flag come from logic on clk
// Notes: Stream uses valid/ready; truncated to the smaller of request and total
`timescale 1ns/1ns
module udr_top
	import udr_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic firmware_takeover_flag,
	input wire udr_req_s req,
	input wire logic out_ready,
	output udr_byte_s out,
	output logic busy,
	output logic done,
	output logic refused
);
	udr_top_s st_q;
	udr_top_s st_d;
	logic [7:0] rom_data;
	logic take;

	udr_rom u_rom
	(
		.index(st_q.index),
		.data(rom_data)
	);

	always_comb
	begin
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.refused = 1'b0;
		take = !st_q.out.valid || out_ready;
		case (st_q.state)
			UDR_IDLE:
			begin
				if (req.valid)
				begin
					if (firmware_takeover_flag)
						st_d.refused = 1'b1;
					else
					begin
						st_d.state = UDR_SERVE;
						st_d.busy = 1'b1;
						st_d.index = 8'h00;
						st_d.remain = (req.length < TOTAL_LEN) ? req.length : TOTAL_LEN;
					end
				end
			end
			UDR_SERVE:
			begin
				if (firmware_takeover_flag)
				begin
					st_d.state = UDR_IDLE;
					st_d.busy = 1'b0;
					st_d.done = 1'b1;
					st_d.out = '0;
				end
				else if (take)
				begin
					if (st_q.remain == 16'h0000)
					begin
						st_d.out = '0;
						st_d.state = UDR_IDLE;
						st_d.busy = 1'b0;
						st_d.done = 1'b1;
					end
					else
					begin
						st_d.out.valid = 1'b1;
						st_d.out.data = rom_data;
						st_d.out.last = (st_q.remain == 16'h0001);
						st_d.index = 8'(st_q.index + 8'h01);
						st_d.remain = 16'(st_q.remain - 16'h0001);
					end
				end
			end
			default:
			begin
				st_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign out = st_q.out;
	assign busy = st_q.busy;
	assign done = st_q.done;
	assign refused = st_q.refused;
endmodule : udr_top

// ===== sim/udr_top_asserts.sv
// Purpose: Port checks for udr_top
// Assumes: One clock, srst synchronous active high
// Notes: Bound to every udr_top instance
`timescale 1ns/1ns
module udr_top_asserts
	import udr_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic firmware_takeover_flag,
	input wire udr_req_s req,
	input wire logic out_ready,
	input wire udr_byte_s out,
	input wire logic busy,
	input wire logic done,
	input wire logic refused
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_take;
		req.valid && !busy && !firmware_takeover_flag;
	endsequence
	sequence s_first;
		out.valid && out.data == 8'h09;
	endsequence
	AST_REFUSE: assert property (req.valid && !busy && firmware_takeover_flag |=> refused && !busy)
		else $error("no refusal");
	AST_ABORT: assert property (busy && firmware_takeover_flag |=> !out.valid)
		else $error("byte after takeover");
	AST_BUSY: assert property (s_take |=> busy)
		else $error("busy missing");
	AST_FIRST: assert property (s_take ##0 req.length != 16'h0000 |=> ##1 s_first)
		else $error("first byte wrong");
	AST_ZERO: assert property (s_take ##0 req.length == 16'h0000 |=> ##1 done)
		else $error("empty request not done");
	AST_HOLD: assert property (out.valid && !out_ready && !firmware_takeover_flag |=> out.valid && $stable(out.data))
		else $error("byte not held");
	AST_LAST: assert property (out.valid && out.last && out_ready |=> done && !busy)
		else $error("no done after last");
	AST_IDLE: assert property (!busy |-> !out.valid)
		else $error("byte while idle");
	AST_PULSE: assert property (done |=> !done)
		else $error("done too long");
endmodule : udr_top_asserts
bind udr_top udr_top_asserts u_chk (.clk(clk), .srst(srst), .firmware_takeover_flag(firmware_takeover_flag),
	.req(req), .out_ready(out_ready), .out(out), .busy(busy), .done(done), .refused(refused));

// ===== sim/udr_host.sv
// Purpose: Host side that takes descriptor bytes
// Assumes: Bench pulses clear at the start of each test task, not before t_short's second request
// Notes: With stall set, ready drops one cycle in three
`timescale 1ns/1ns
module udr_host
	import udr_pkg::*;
(
	input wire logic clk,
	input wire logic stall,
	input wire logic clear,
	input wire udr_byte_s out,
	output logic out_ready,
	output logic [7:0] got [256],
	output int n,
	output logic saw_last
);
	int t = 0;
	initial out_ready = 1'b0;
	always @(negedge clk)
	begin
		t <= t + 1;
		out_ready <= !(stall && t % 3 == 0);
	end
	always @(posedge clk)
	begin
		if (clear)
		begin
			n <= 0;
			saw_last <= 1'b0;
		end
		else if (out.valid && out_ready)
		begin
			got[n[7:0]] <= out.data;
			n <= n + 1;
			saw_last <= out.last;
		end
	end
endmodule : udr_host

// ===== sim/testbench.sv
// Purpose: Self-checking bench for udr_top
// Assumes: Inputs change on the falling edge
// Notes: Expected bytes rebuilt here from the descriptor layout
`timescale 1ns/1ns
module testbench;
	import udr_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic flag = 1'b0;
	udr_req_s req = '0;
	logic stall = 1'b0;
	logic clear = 1'b1;
	logic out_ready;
	udr_byte_s out;
	logic busy;
	logic done;
	logic refused;
	logic [7:0] got [256];
	int n;
	logic saw_last;
	logic [7:0] ex [256];
	int k = 0;
	int fail_count = 0;
	int n_compared = 0;
	udr_top DUT (.clk(clk), .srst(srst), .firmware_takeover_flag(flag), .req(req), .out_ready(out_ready),
		.out(out), .busy(busy), .done(done), .refused(refused));
	udr_host host (.clk(clk), .stall(stall), .clear(clear), .out(out), .out_ready(out_ready), .got(got),
		.n(n), .saw_last(saw_last));
	initial forever #5 clk = ~clk;
	task chk(input logic bad, input string m);
		n_compared++;
		if (bad)
		begin
			fail_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task put(input logic [7:0] b);
		ex[k] = b;
		k++;
	endtask : put
	task build;
		logic [15:0] m;
		logic [7:0] f [9];
		logic [7:0] ad [13];
		logic [7:0] e7 [7];
		f = '{8'h09, 8'h02, 8'hDA, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'h32};
		ad = '{8'h81, 8'h82, 8'h02, 8'h84, 8'h04, 8'h86, 8'h06, 8'h88, 8'h08, 8'h89,
			8'h09, 8'h8A, 8'h0A};
		for (int i = 0; i < 9; i++) put(f[i]);
		for (int a = 0; a < 3; a++)
		begin
			f = '{8'h09, 8'h04, 8'h00, a[7:0], (a > 0) ? 8'h0D : 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
			for (int i = 0; i < 9; i++) put(f[i]);
			for (int e = 0; e < 13 && a > 0; e++)
			begin
				m = (e == 0) ? ((a == 2) ? 16'h0040 : 16'h0010) : (e < 7) ? 16'h0040 :
					(a == 2 && e < 9) ? 16'h0100 : 16'h0010;
				e7 = '{8'h07, 8'h05, ad[e], (e == 0) ? 8'h03 : (e < 7) ? 8'h02 : 8'h01, m[7:0], m[15:8],
					(e == 0) ? 8'h0A : (e < 7) ? 8'h00 : 8'h01};
				for (int i = 0; i < 7; i++) put(e7[i]);
			end
		end
	endtask : build
	task ask(input logic [15:0] len, input int gap);
		@(negedge clk) clear = 1'b0;
		req = '{1'b1, len};
		@(negedge clk) req.valid = 1'b0;
		repeat (gap) @(negedge clk);
		if (gap > 0) flag = 1'b1;
		for (int i = 0; i < 1000 && done !== 1'b1 && refused !== 1'b1; i++) @(negedge clk);
		chk(done !== 1'b1 && refused !== 1'b1, "no end");
	endtask : ask
	task t_full;
		clear = 1'b1;
		stall = 1'b1;
		ask(16'h0100, 0);
		chk(n != 218, "count");
		for (int i = 0; i < 218; i++) chk(got[i] !== ex[i], "byte");
		chk(saw_last !== 1'b1, "last");
		chk(got[5] !== 8'h01, "config value");
		stall = 1'b0;
		$display("t_full end");
	endtask : t_full
	task t_short;
		clear = 1'b1;
		ask(16'h0002, 0);
		ask(16'h0000, 0);
		chk(n != 2 || got[0] !== 8'h09 || got[1] !== 8'h02 || saw_last !== 1'b1, "short");
		$display("t_short end");
	endtask : t_short
	task t_refuse;
		clear = 1'b1;
		flag = 1'b1;
		ask(16'h0010, 0);
		chk(refused !== 1'b1 || n != 0, "refuse");
		flag = 1'b0;
		clear = 1'b1;
		ask(16'h00DA, 20);
		chk(n >= 218 || n == 0 || saw_last !== 1'b0 || busy !== 1'b0, "abort");
		flag = 1'b0;
		$display("t_refuse end");
	endtask : t_refuse
	task finish_test;
		$display("%0d compared, %0d failed", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	initial
	begin
		build();
		repeat (20) @(negedge clk);
		srst = 1'b0;
		t_full();
		t_short();
		t_refuse();
		finish_test();
	end
	initial
	begin
		#100000;
		$display("[ERR] %0t timeout", $time);
		fail_count++;
		finish_test();
	end
endmodule : testbench
